/* hdl/bdp_pkg.sv */
// shared constants and types of the bulky data port
package bdp_pkg;
    // port modes: A read-controlled, B free-running read, C sampled, D half duplex
    typedef enum logic [1:0] {
        BDP_MODE_A = 2'b00,
        BDP_MODE_B = 2'b01,
        BDP_MODE_C = 2'b10,
        BDP_MODE_D = 2'b11
    } bdp_mode_t;

    localparam int BYTE_W = 8;
    localparam int FMT_W  = 3;
    localparam int WORD_W = BYTE_W + FMT_W;
    localparam int FMT_TOP = 2;

    // format bus codes
    localparam logic [FMT_W-1:0] FMT_VIDEO_START = 3'h5;
    localparam logic [FMT_W-1:0] FMT_VIDEO_BYTE  = 3'h1;
    localparam logic [FMT_W-1:0] FMT_IDLE        = 3'h4;

    // transmit buffer
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW    = $clog2(FIFO_DEPTH);
    localparam int QUAD_BYTES = 4;
    localparam int QUAD_W     = $clog2(QUAD_BYTES);

    // timing: system clock period, network sample clock divider, sampled-mode spacing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int SAMPLE_DIV     = 2;
    localparam int C_SPACING_NET  = 4;
    localparam int C_SPACING_SYS  = SAMPLE_DIV * C_SPACING_NET;
    localparam int C_GAP_W        = $clog2(C_SPACING_SYS);
    localparam logic [C_GAP_W-1:0] C_GAP_LOAD = C_GAP_W'(C_SPACING_SYS - 1);
    localparam logic [C_GAP_W-1:0] C_PULSE_LEN = C_GAP_W'(C_SPACING_SYS / 2);
endpackage : bdp_pkg

/* hdl/bdp_if.sv */
// pins between the device end and the host end of the bulky data port
`timescale 1ns/1ps
interface bdp_if;
    logic [bdp_pkg::BYTE_W-1:0] in_byte_h;            // host drive of input byte bus
    logic [bdp_pkg::FMT_W-1:0]  in_fmt_h;             // host drive of input format bus
    logic                       in_oe_h;              // host enables its drive
    logic [bdp_pkg::BYTE_W-1:0] in_byte_d;            // device drive (mode D reads)
    logic [bdp_pkg::FMT_W-1:0]  in_fmt_d;             // device drive of format bus
    logic                       in_oe_d;              // device enables its drive
    logic [bdp_pkg::BYTE_W-1:0] input_byte_bus;       // resolved shared byte bus
    logic [bdp_pkg::FMT_W-1:0]  input_format_bus;     // resolved shared format bus
    logic [bdp_pkg::BYTE_W-1:0] output_byte_bus;      // device read data
    logic [bdp_pkg::FMT_W-1:0]  output_format_bus;    // device read format
    logic                       input_qualifier;      // host write qualifier / rw enable
    logic                       output_enable_rw;     // host read enable / rw select
    logic                       write_busy;           // device cannot take writes
    logic                       read_data_available;  // device holds read data
    logic                       network_sample_clock; // half-rate sample clock

    // wire resolution of the shared buses
    assign input_byte_bus   = in_oe_d ? in_byte_d : (in_oe_h ? in_byte_h : '0);
    assign input_format_bus = in_oe_d ? in_fmt_d : (in_oe_h ? in_fmt_h : '0);

    modport dev (
        input  input_byte_bus, input_format_bus, input_qualifier, output_enable_rw,
        output in_byte_d, in_fmt_d, in_oe_d, output_byte_bus, output_format_bus,
        output write_busy, read_data_available, network_sample_clock
    );
    modport host (
        input  input_byte_bus, input_format_bus, in_oe_d, output_byte_bus,
        input  output_format_bus, write_busy, read_data_available, network_sample_clock,
        output in_byte_h, in_fmt_h, in_oe_h, input_qualifier, output_enable_rw
    );
endinterface : bdp_if

/* hdl/bdp_fifo.sv */
// transmit buffer with a registered show-ahead output stage
`timescale 1ns/1ps
module bdp_fifo #(
    parameter int W     = bdp_pkg::WORD_W,
    parameter int DEPTH = bdp_pkg::FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         clk,       // clock
    input  wire logic         rst_n,     // async reset, active low
    input  wire logic         in_valid,  // write request
    output logic              in_ready,  // room in the array
    input  wire logic [W-1:0] in_data,   // write word
    output logic              out_valid, // output stage full
    input  wire logic         out_ready, // drain side takes the word
    output logic [W-1:0]      out_data,  // output word
    output logic [AW:0]       level      // words in the array
);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic          push;
    logic          pop;

    // handshakes on both sides
    assign in_ready = (level != FULL_CNT);
    assign push     = in_valid && in_ready;
    assign pop      = (level != '0) && (!out_valid || out_ready);

    // array write
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            level  <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // output stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else if (pop)
        begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end
        else if (out_ready)
        begin
            out_valid <= 1'b0;
        end
    end
endmodule : bdp_fifo

/* hdl/bdp_dev.sv */
// device end of the bulky data port: mode handshakes, transmit buffer, receive holding
// Operation
// - sampled mode: one write per four sample cycles
// - host idles qualifier one sample between writes
// - sampled mode: video only, top format bit
// - unidirectional reads carry a three-bit format
// - mode A advances only on output enable
// - mode B presents data without host signal
// - data-available when holding register is loaded
// - sampled mode: one read per four samples
// - host idles output enable between reads
// - sampled read data valid after enable edge
// - only mode D shares the input bus
// - codes: start 101, byte 001, idle 100
// - mode D: qualifier enables, enable selects read
// - busy when buffer full, refuse writes; mode C holds busy low and drops writes while the buffer is full
// - mode D: data-available while data held
// - busy rises only on quadlet boundaries
// - sample clock runs at half system clock
`timescale 1ns/1ps
module bdp_dev #(
    parameter int DEPTH = bdp_pkg::FIFO_DEPTH
) (
    input  wire logic                       SYS_CLK,  // system clock
    input  wire logic                       RST_N,    // async reset, active low
    input  wire bdp_pkg::bdp_mode_t         MODE,     // port mode
    bdp_if.dev                              LINK,     // pins toward the host
    output logic [bdp_pkg::BYTE_W-1:0]      TX_DATA,  // written byte to the link layer
    output logic [bdp_pkg::FMT_W-1:0]       TX_FMT,   // its format code
    output logic                            TX_VALID, // written byte waiting
    input  wire logic                       TX_READY, // link layer takes it
    input  wire logic [bdp_pkg::BYTE_W-1:0] RX_DATA,  // received byte for the host
    input  wire logic [bdp_pkg::FMT_W-1:0]  RX_FMT,   // its format code
    input  wire logic                       RX_VALID, // received byte offered
    output logic                            RX_READY  // holding register empty
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] QUAD_CNT = (AW+1)'(bdp_pkg::QUAD_BYTES);

    logic                          net_clk;
    logic                          phase;
    logic                          qual_prev;
    logic                          oe_prev;
    logic [bdp_pkg::C_GAP_W-1:0]   wr_gap;
    logic [bdp_pkg::C_GAP_W-1:0]   rd_gap;
    logic                          c_mode;
    logic                          d_mode;
    logic                          wr_take;
    logic [bdp_pkg::FMT_W-1:0]     wr_fmt;
    logic                          fifo_in_ready;
    logic [bdp_pkg::WORD_W-1:0]    tx_word;
    logic [AW:0]                   level;
    logic [AW:0]                   free_after;
    logic [bdp_pkg::QUAD_W-1:0]    quad_cnt;
    logic [bdp_pkg::QUAD_W-1:0]    next_quad_cnt;
    logic                          hold_valid;
    logic [bdp_pkg::BYTE_W-1:0]    hold_data;
    logic [bdp_pkg::FMT_W-1:0]     hold_fmt;
    logic                          rd_take;
    logic                          next_hold_valid;

    assign c_mode = (MODE == bdp_pkg::BDP_MODE_C);
    assign d_mode = (MODE == bdp_pkg::BDP_MODE_D);
    assign phase  = !net_clk;  // the sample clock rises at the end of this cycle

    // half-rate network sample clock, driven out to the host
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            net_clk <= 1'b0;
        end
        else
        begin
            net_clk <= !net_clk;
        end
    end
    assign LINK.network_sample_clock = net_clk;

    // levels of the enables seen at the previous sample, for edge detection
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            qual_prev <= 1'b0;
            oe_prev   <= 1'b0;
        end
        else if (phase)
        begin
            qual_prev <= LINK.input_qualifier;
            oe_prev   <= LINK.output_enable_rw;
        end
    end

    // write acceptance for every mode
    always_comb
    begin
        wr_take = 1'b0;
        wr_fmt  = LINK.input_format_bus;
        if (c_mode)
        begin
            // a fresh qualifier edge after an idle sample, with spacing elapsed
            wr_take = phase && LINK.input_qualifier && !qual_prev && (wr_gap == '0);
            wr_fmt  = LINK.input_format_bus[bdp_pkg::FMT_TOP] ? bdp_pkg::FMT_VIDEO_START
                                                              : bdp_pkg::FMT_VIDEO_BYTE;
        end
        else
        begin
            // mode D writes need the read select low; idle bytes are not stored
            wr_take = LINK.input_qualifier && !LINK.write_busy
                      && !(d_mode && LINK.output_enable_rw)
                      && (LINK.input_format_bus != bdp_pkg::FMT_IDLE);
        end
        wr_take = wr_take && fifo_in_ready;
    end

    // transmit buffer toward the link layer
    bdp_fifo #(
        .W     (bdp_pkg::WORD_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_tx_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RST_N),
        .in_valid  (wr_take),
        .in_ready  (fifo_in_ready),
        .in_data   ({wr_fmt, LINK.input_byte_bus}),
        .out_valid (TX_VALID),
        .out_ready (TX_READY),
        .out_data  (tx_word),
        .level     (level)
    );
    assign TX_DATA = tx_word[bdp_pkg::BYTE_W-1:0];
    assign TX_FMT  = tx_word[bdp_pkg::WORD_W-1:bdp_pkg::BYTE_W];

    // quadlet position and room left once this cycle's byte is stored
    assign next_quad_cnt = quad_cnt + bdp_pkg::QUAD_W'(wr_take);
    assign free_after    = FULL_CNT - level - (AW+1)'(wr_take);

    // busy rises only at a quadlet boundary, so a started quadlet always fits
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            quad_cnt        <= '0;
            LINK.write_busy <= 1'b0;
        end
        else
        begin
            quad_cnt <= c_mode ? '0 : next_quad_cnt;
            if (c_mode)
            begin
                LINK.write_busy <= 1'b0;
            end
            else if (next_quad_cnt == '0 && free_after < QUAD_CNT)
            begin
                LINK.write_busy <= 1'b1;
            end
            else if (free_after >= QUAD_CNT)
            begin
                LINK.write_busy <= 1'b0;
            end
        end
    end

    // read consumption per mode
    always_comb
    begin
        rd_take = 1'b0;
        unique case (MODE)
            bdp_pkg::BDP_MODE_A: rd_take = hold_valid && LINK.output_enable_rw;
            bdp_pkg::BDP_MODE_B: rd_take = hold_valid;
            bdp_pkg::BDP_MODE_C: rd_take = hold_valid && phase && (rd_gap == '0)
                                           && LINK.output_enable_rw && !oe_prev;
            bdp_pkg::BDP_MODE_D: rd_take = hold_valid && LINK.input_qualifier
                                           && LINK.output_enable_rw;
        endcase
    end
    assign next_hold_valid = (hold_valid && !rd_take) || (RX_VALID && RX_READY);

    // sampled-mode spacing counters, four sample cycles after each transfer
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_gap <= '0;
            rd_gap <= '0;
        end
        else
        begin
            wr_gap <= (wr_take && c_mode) ? bdp_pkg::C_GAP_LOAD
                      : ((wr_gap != '0) ? wr_gap - 1'b1 : wr_gap);
            rd_gap <= (rd_take && c_mode) ? bdp_pkg::C_GAP_LOAD
                      : ((rd_gap != '0) ? rd_gap - 1'b1 : rd_gap);
        end
    end

    // receive holding register and data-available flag
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            hold_valid               <= 1'b0;
            hold_data                <= '0;
            hold_fmt                 <= bdp_pkg::FMT_IDLE;
            RX_READY                 <= 1'b1;
            LINK.read_data_available <= 1'b0;
        end
        else
        begin
            hold_valid               <= next_hold_valid;
            RX_READY                 <= !next_hold_valid;
            LINK.read_data_available <= next_hold_valid;
            if (RX_VALID && RX_READY)
            begin
                hold_data <= RX_DATA;
                hold_fmt  <= RX_FMT;
            end
        end
    end

    // separate output bus for modes A, B, C; idle code marks no byte
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LINK.output_byte_bus   <= '0;
            LINK.output_format_bus <= bdp_pkg::FMT_IDLE;
        end
        else if (rd_take && !d_mode)
        begin
            LINK.output_byte_bus   <= hold_data;
            LINK.output_format_bus <= hold_fmt;
        end
        else
        begin
            LINK.output_format_bus <= bdp_pkg::FMT_IDLE;
        end
    end

    // mode D reads turn the shared bus around for one cycle
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LINK.in_oe_d   <= 1'b0;
            LINK.in_byte_d <= '0;
            LINK.in_fmt_d  <= bdp_pkg::FMT_IDLE;
        end
        else
        begin
            LINK.in_oe_d <= rd_take && d_mode;
            if (rd_take && d_mode)
            begin
                LINK.in_byte_d <= hold_data;
                LINK.in_fmt_d  <= hold_fmt;
            end
        end
    end
endmodule : bdp_dev

/* hdl/bdp_host.sv */
// host end of the bulky data port: issues writes and reads in each mode
`timescale 1ns/1ps
module bdp_host (
    input  wire logic                       SYS_CLK,  // system clock
    input  wire logic                       RST_N,    // async reset, active low
    input  wire bdp_pkg::bdp_mode_t         MODE,     // port mode, same as device
    bdp_if.host                             LINK,     // pins toward the device
    input  wire logic                       WR_VALID, // byte to write
    input  wire logic [bdp_pkg::BYTE_W-1:0] WR_DATA,  // write byte
    input  wire logic [bdp_pkg::FMT_W-1:0]  WR_FMT,   // write format code
    output logic                            WR_READY, // write slot free
    input  wire logic                       RD_REQ,   // user wants read data
    output logic                            RD_VALID, // read byte arrived, one cycle
    output logic [bdp_pkg::BYTE_W-1:0]      RD_DATA,  // read byte
    output logic [bdp_pkg::FMT_W-1:0]       RD_FMT    // read format code
);
    logic                         pend;
    logic [bdp_pkg::BYTE_W-1:0]   pend_data;
    logic [bdp_pkg::FMT_W-1:0]    pend_fmt;
    logic                         wr_acc;
    logic                         wr_done;
    logic                         next_pend;
    logic [bdp_pkg::BYTE_W-1:0]   next_data;
    logic [bdp_pkg::FMT_W-1:0]    next_fmt;
    logic                         c_active;
    logic                         c_write;
    logic [bdp_pkg::C_GAP_W-1:0]  pace;
    logic                         c_start;
    logic                         want_wr;
    logic                         want_rd;

    // write request bookkeeping
    always_comb
    begin
        wr_acc = WR_VALID && WR_READY;
        if (MODE == bdp_pkg::BDP_MODE_C)
        begin
            wr_done = c_active && c_write && (pace == bdp_pkg::C_GAP_LOAD);
        end
        else
        begin
            wr_done = LINK.input_qualifier && !LINK.write_busy
                      && !(MODE == bdp_pkg::BDP_MODE_D && LINK.output_enable_rw);
        end
        next_pend = (pend && !wr_done) || wr_acc;
        next_data = wr_acc ? WR_DATA : pend_data;
        next_fmt  = wr_acc ? WR_FMT : pend_fmt;
        c_start   = !c_active && (next_pend || (RD_REQ && LINK.read_data_available));
        want_wr   = next_pend
                    && !(LINK.input_qualifier && LINK.output_enable_rw);
        want_rd   = (MODE == bdp_pkg::BDP_MODE_D) && RD_REQ
                    && LINK.read_data_available && !want_wr;
    end

    // pending byte and user handshake
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pend      <= 1'b0;
            pend_data <= '0;
            pend_fmt  <= bdp_pkg::FMT_IDLE;
            WR_READY  <= 1'b1;
        end
        else
        begin
            pend      <= next_pend;
            pend_data <= next_data;
            pend_fmt  <= next_fmt;
            WR_READY  <= !next_pend;
        end
    end

    // sampled-mode pacing: enables high for four cycles, then low for the following five
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            c_active <= 1'b0;
            c_write  <= 1'b0;
            pace     <= '0;
        end
        else if (MODE != bdp_pkg::BDP_MODE_C)
        begin
            c_active <= 1'b0;
            pace     <= '0;
        end
        else if (c_start)
        begin
            c_active <= 1'b1;
            c_write  <= next_pend;
            pace     <= '0;
        end
        else if (c_active)
        begin
            c_active <= (pace != bdp_pkg::C_GAP_LOAD);
            pace     <= pace + 1'b1;
        end
    end

    // pin drive per mode
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            LINK.input_qualifier  <= 1'b0;
            LINK.output_enable_rw <= 1'b0;
            LINK.in_oe_h          <= 1'b0;
            LINK.in_byte_h        <= '0;
            LINK.in_fmt_h         <= bdp_pkg::FMT_IDLE;
        end
        else
        begin
            LINK.in_byte_h <= next_data;
            LINK.in_fmt_h  <= next_fmt;
            unique case (MODE)
                bdp_pkg::BDP_MODE_A, bdp_pkg::BDP_MODE_B:
                begin
                    LINK.input_qualifier  <= next_pend;
                    LINK.output_enable_rw <= (MODE == bdp_pkg::BDP_MODE_A) && RD_REQ;
                    LINK.in_oe_h          <= 1'b1;
                end
                bdp_pkg::BDP_MODE_C:
                begin
                    LINK.input_qualifier  <= c_start ? next_pend
                                             : (c_active && c_write
                                                && pace < bdp_pkg::C_PULSE_LEN - 3'h1);
                    LINK.output_enable_rw <= c_start ? !next_pend
                                             : (c_active && !c_write
                                                && pace < bdp_pkg::C_PULSE_LEN - 3'h1);
                    LINK.in_oe_h          <= 1'b1;
                end
                bdp_pkg::BDP_MODE_D:
                begin
                    LINK.input_qualifier  <= want_wr || want_rd;
                    LINK.output_enable_rw <= want_rd;
                    LINK.in_oe_h          <= want_wr;  // released for device turnaround
                end
            endcase
        end
    end

    // read capture: shared bus in mode D, separate bus otherwise
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            RD_VALID <= 1'b0;
            RD_DATA  <= '0;
            RD_FMT   <= bdp_pkg::FMT_IDLE;
        end
        else if (MODE == bdp_pkg::BDP_MODE_D)
        begin
            RD_VALID <= LINK.in_oe_d;
            RD_DATA  <= LINK.input_byte_bus;
            RD_FMT   <= LINK.input_format_bus;
        end
        else
        begin
            RD_VALID <= (LINK.output_format_bus != bdp_pkg::FMT_IDLE);
            RD_DATA  <= LINK.output_byte_bus;
            RD_FMT   <= LINK.output_format_bus;
        end
    end
endmodule : bdp_host

/* bench/bdp_sva.sv */
// pin-level checks between the device end and the host end
`timescale 1ns/1ps
module bdp_sva (
    input wire logic                      SYS_CLK,              // clock
    input wire logic                      RST_N,                // reset, active low
    input wire bdp_pkg::bdp_mode_t        MODE,                 // port mode
    input wire logic                      in_oe_d,              // device bus drive
    input wire logic [bdp_pkg::FMT_W-1:0] output_format_bus,    // read format
    input wire logic                      input_qualifier,      // qualifier
    input wire logic                      output_enable_rw,     // read enable
    input wire logic                      read_data_available,  // data held
    input wire logic                      network_sample_clock  // sample clock
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // quiet read bus for the rest of a sampled-mode slot
    sequence s_gap;
        (output_format_bus == bdp_pkg::FMT_IDLE) [*7];
    endsequence
    a_clk_half_rate: assert property ($past(RST_N) |-> network_sample_clock != $past(network_sample_clock))
        else $error("sample clock did not toggle");
    a_d_drive_only: assert property (MODE != bdp_pkg::BDP_MODE_D |-> !in_oe_d)
        else $error("shared bus driven outside mode d");
    a_d_drive_once: assert property (in_oe_d |=> !in_oe_d)
        else $error("device drive longer than one cycle");
    a_d_read_drive: assert property (MODE == bdp_pkg::BDP_MODE_D && input_qualifier && output_enable_rw
        && read_data_available |=> in_oe_d)
        else $error("mode d read not answered");
    a_a_read_byte: assert property (MODE == bdp_pkg::BDP_MODE_A && output_enable_rw
        && read_data_available |=> output_format_bus != bdp_pkg::FMT_IDLE)
        else $error("mode a read gave no byte");
    a_a_no_enable: assert property (MODE == bdp_pkg::BDP_MODE_A && !output_enable_rw
        |=> output_format_bus == bdp_pkg::FMT_IDLE)
        else $error("mode a byte without enable");
    a_b_push_byte: assert property (MODE == bdp_pkg::BDP_MODE_B && $rose(read_data_available)
        |=> output_format_bus != bdp_pkg::FMT_IDLE)
        else $error("mode b byte not pushed");
    a_c_read_gap: assert property (MODE == bdp_pkg::BDP_MODE_C
        && output_format_bus != bdp_pkg::FMT_IDLE |=> s_gap)
        else $error("sampled reads too close");
endmodule : bdp_sva

/* bench/bulky_data_port_timing_tb_top.sv */
// bench: both ends back to back, user traffic in every mode
`timescale 1ns/1ps
module bulky_data_port_timing_tb_top;
    logic               sys_clk = 1'b0;  // system clock
    logic               rst_n = 1'b0;    // reset
    bdp_pkg::bdp_mode_t mode = bdp_pkg::BDP_MODE_A;
    logic               wr_valid = 1'b0, rd_req = 1'b1, tx_ready = 1'b1, rx_valid = 1'b0;
    logic [7:0]         wr_data = 8'h00, rx_data = 8'h00, rd_data, tx_data;
    logic [2:0]         wr_fmt = 3'h1, rx_fmt = 3'h1, rd_fmt, tx_fmt;
    logic               wr_ready, rd_valid, tx_valid, rx_ready, pbusy;
    logic [10:0]        tx_q[$], rd_q[$];
    int                 errors = 0, compares = 0, cyc = 0, lcnt = 0, wn = 0, i, j, k;
    logic [2:0]         wfmt[4] = '{3'h5, 3'h1, 3'h2, 3'h6};
    bdp_if link ();
    bdp_dev u_bdp_dev (.SYS_CLK(sys_clk), .RST_N(rst_n), .MODE(mode), .LINK(link.dev),
        .TX_DATA(tx_data), .TX_FMT(tx_fmt), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .RX_DATA(rx_data), .RX_FMT(rx_fmt), .RX_VALID(rx_valid), .RX_READY(rx_ready));
    bdp_host u_bdp_host (.SYS_CLK(sys_clk), .RST_N(rst_n), .MODE(mode), .LINK(link.host),
        .WR_VALID(wr_valid), .WR_DATA(wr_data), .WR_FMT(wr_fmt), .WR_READY(wr_ready),
        .RD_REQ(rd_req), .RD_VALID(rd_valid), .RD_DATA(rd_data), .RD_FMT(rd_fmt));
    bdp_sva u_bdp_sva (.SYS_CLK(sys_clk), .RST_N(rst_n), .MODE(mode), .in_oe_d(link.in_oe_d),
        .output_format_bus(link.output_format_bus), .input_qualifier(link.input_qualifier),
        .output_enable_rw(link.output_enable_rw), .read_data_available(link.read_data_available),
        .network_sample_clock(link.network_sample_clock));
    always #20 sys_clk = ~sys_clk;
    // capture user outputs, count mode d link writes, cut a hang short
    always @(negedge sys_clk)
    begin
        cyc++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) tx_q.push_back({tx_fmt, tx_data});
        if (rd_valid === 1'b1) rd_q.push_back({rd_fmt, rd_data});
        if (link.write_busy === 1'b1 && pbusy !== 1'b1) chk(11'(lcnt % 4), 11'h0);
        pbusy = link.write_busy;
        if (mode == bdp_pkg::BDP_MODE_D && link.input_qualifier === 1'b1
            && link.write_busy === 1'b0 && link.output_enable_rw === 1'b0) lcnt++;
        if (cyc == 40000) begin errors++; test_done(); end
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        compares++;
        if (got !== exp) begin errors++; $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp); end
    endtask : chk
    task automatic rst(input bdp_pkg::bdp_mode_t m, input int n);
        rst_n = 1'b0;
        mode = m;
        repeat (n) @(negedge sys_clk);
        tx_q.delete();
        rd_q.delete();
        lcnt = 0;
        rst_n = 1'b1;
    endtask : rst
    // write through the host user side; valid stays up for back-to-back use
    task automatic wr(input logic [7:0] d, input logic [2:0] f);
        wr_valid = 1'b1;
        wr_data = d;
        wr_fmt = f;
        for (wn = 0; wr_ready !== 1'b1 && wn < 60; wn++) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask : wr
    task automatic rx(input logic [10:0] w);
        rx_valid = 1'b1;
        {rx_fmt, rx_data} = w;
        while (rx_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        rx_valid = 1'b0;
        @(negedge sys_clk);
    endtask : rx
    task automatic test_done();
        $display("compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    initial
    begin
        @(negedge sys_clk);
        rst(bdp_pkg::BDP_MODE_A, 20);
        for (k = 0; k < 4; k++)
        begin
            rst(bdp_pkg::bdp_mode_t'(k), 2);
            for (i = 0; i < 4; i++) wr(8'h30 + 8'(i), wfmt[i]);
            wr_valid = 1'b0;
            for (i = 0; i < 2; i++) rx({3'h5, 8'ha0 + 8'(i)});
            repeat (80) @(negedge sys_clk);
            chk(11'(tx_q.size()), 11'h4);
            chk(11'(rd_q.size()), 11'h2);
            for (i = 0; i < 4; i++) chk(tx_q[i], {k == 2 ? {wfmt[i][2], 2'b01} : wfmt[i], 8'h30 + 8'(i)});
            for (i = 0; i < 2; i++) chk(rd_q[i], {3'h5, 8'ha0 + 8'(i)});
            $display("mode %0d test done, errors %0d", k, errors);
        end
        // fill the buffer with the link layer stalled, then drain it
        tx_ready = 1'b0;
        rst(bdp_pkg::BDP_MODE_D, 2);
        for (i = 0; i < 40 && wn < 60; i++) wr(8'(i), 3'h1);
        chk({10'h0, link.write_busy}, 11'h1);
        tx_ready = 1'b1;
        wr(wr_data, wr_fmt);
        wr_valid = 1'b0;
        repeat (80) @(negedge sys_clk);
        chk({10'h0, link.write_busy}, 11'h0);
        chk(11'(tx_q.size()), 11'(i));
        for (j = 0; j < i; j++) chk(tx_q[j], {3'h1, 8'(j)});
        $display("busy test done, errors %0d", errors);
        test_done();
    end
endmodule : bulky_data_port_timing_tb_top
